//--- hw/fbmc_cycle.sv
// fbmc_cycle: runs one asynchronous flash bus cycle (write or read) on the pins
// assumes: flash dq input already synchronous to clk
`timescale 1ns/1ps
module fbmc_cycle (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	// cycle request
	input  wire fbmc_pkg::fbmc_cyc_t  cyc,
	input  wire logic                 cyc_valid,
	output logic                      cyc_ready,
	output logic                      cyc_done,
	output logic [7:0]                cyc_rdata,
	// flash pins
	output fbmc_pkg::fbmc_pins_t      pins,
	input  wire logic [7:0]           dq_in
);
	import fbmc_pkg::*;
	typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_PULSE, CY_RECOV} fbmc_cy_t;
	fbmc_cy_t             st_reg, st_next;
	logic [CNT_W-1:0]     cnt_reg, cnt_next;
	fbmc_pins_t           pins_reg, pins_next;
	logic [7:0]           rd_reg, rd_next;
	logic                 done_reg, done_next;
	logic                 wr_reg, wr_next;

	always_comb begin
		st_next   = st_reg;
		cnt_next  = cnt_reg;
		pins_next = pins_reg;
		rd_next   = rd_reg;
		wr_next   = wr_reg;
		done_next = 1'b0;
		unique case (st_reg)
			CY_IDLE: if (cyc_valid) begin
				// address and ce go first so the we fall is the later edge and latches address
				pins_next.addr   = cyc.addr;
				pins_next.ce_n   = 1'b0;
				pins_next.dq_out = cyc.data;
				pins_next.dq_oe  = cyc.wr;
				wr_next  = cyc.wr;
				cnt_next = CNT_W'(C_SETUP);
				st_next  = CY_SETUP;
			end
			CY_SETUP: if (cnt_reg <= CNT_W'(1)) begin
				pins_next.we_n = ~wr_reg;
				pins_next.oe_n = wr_reg;
				cnt_next = wr_reg ? CNT_W'(C_PULSE) : CNT_W'(C_READ);
				st_next  = CY_PULSE;
			end else begin
				cnt_next = cnt_reg - CNT_W'(1);
			end
			CY_PULSE: if (cnt_reg <= CNT_W'(1)) begin
				// we rises before ce so data is latched by we with data still held
				pins_next.we_n = 1'b1;
				pins_next.oe_n = 1'b1;
				rd_next  = dq_in;
				cnt_next = CNT_W'(C_RECOV);
				st_next  = CY_RECOV;
			end else begin
				cnt_next = cnt_reg - CNT_W'(1);
			end
			CY_RECOV: if (cnt_reg <= CNT_W'(1)) begin
				pins_next.ce_n  = 1'b1;
				pins_next.dq_oe = 1'b0;
				done_next = 1'b1;
				st_next   = CY_IDLE;
			end else begin
				cnt_next = cnt_reg - CNT_W'(1);
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_reg   <= CY_IDLE;
			cnt_reg  <= '0;
			pins_reg <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0};
			rd_reg   <= '0;
			done_reg <= 1'b0;
			wr_reg   <= 1'b0;
		end else begin
			st_reg   <= st_next;
			cnt_reg  <= cnt_next;
			pins_reg <= pins_next;
			rd_reg   <= rd_next;
			done_reg <= done_next;
			wr_reg   <= wr_next;
		end
	end

	assign cyc_ready = (st_reg == CY_IDLE);
	assign cyc_done  = done_reg;
	assign cyc_rdata = rd_reg;
	assign pins      = pins_reg;
endmodule // fbmc_cycle

//--- hw/fbmc_host.sv
// fbmc_host: host controller that turns requests into flash command sequences in byte mode
// assumes: one flash part on the pins, data lines sampled synchronously, requests held until ready
`timescale 1ns/1ps
module fbmc_host (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	// request port
	input  wire fbmc_pkg::fbmc_req_t    req,
	input  wire logic                   req_valid,
	output logic                        req_ready,
	input  wire logic [7:0]             buf_data,
	output logic                        buf_take,
	output logic                        resp_valid,
	output logic [7:0]                  resp_data,
	output logic                        req_refused,
	output logic                        suspended,
	output logic                        time_limit_flag,
	// flash pins
	output fbmc_pkg::fbmc_pins_t        pins,
	input  wire logic [7:0]             dq_in
);
	import fbmc_pkg::*;
	typedef enum logic [2:0] {H_IDLE, H_STEP, H_WAIT, H_DONE} fbmc_hs_t;
	typedef enum logic [2:0] {M_READ, M_AUTOSEL, M_QUERY, M_SSR, M_ECC} fbmc_mode_t;

	fbmc_hs_t          st_reg, st_next;
	fbmc_mode_t        mode_reg, mode_next;
	fbmc_req_t         cur_reg, cur_next;
	logic [8:0]        step_reg, step_next;
	logic [8:0]        last_reg, last_next;
	logic              erasing_reg, erasing_next;
	logic              susp_reg, susp_next;
	logic [7:0]        resp_reg, resp_next;
	logic              rv_reg, rv_next;
	logic              ref_reg, ref_next;
	logic              tlf_reg, tlf_next;
	fbmc_cyc_t         cyc;
	logic              cyc_valid, cyc_ready, cyc_done;
	logic [7:0]        cyc_rdata;
	logic [ADDR_W-1:0] sect_base, page_addr;
	logic              accept_ok;

	fbmc_cycle fbmc_cycle_inst (
		.clk       (clk),
		.rst_n     (rst_n),
		.cyc       (cyc),
		.cyc_valid (cyc_valid),
		.cyc_ready (cyc_ready),
		.cyc_done  (cyc_done),
		.cyc_rdata (cyc_rdata),
		.pins      (pins),
		.dq_in     (dq_in)
	);

	// ******************************
	// sector and page addressing
	// ******************************
	always_comb begin
		sect_base = cur_reg.boot_part
			? {cur_reg.addr[ADDR_W-1:SECT_LSB_BOOT], {SECT_LSB_BOOT{1'b0}}}
			: {cur_reg.addr[ADDR_W-1:SECT_LSB_UNI], {SECT_LSB_UNI{1'b0}}};
		// loads walk the low byte only, so they never leave the start page
		page_addr = {cur_reg.addr[ADDR_W-1:8], cur_reg.addr[7:0] + step_reg[7:0] - 8'h04};
	end

	// ******************************
	// acceptance by current state and buffer length
	// ******************************
	always_comb begin
		unique case (req.op)
			FBMC_SUSPEND: accept_ok = erasing_reg && !susp_reg;
			FBMC_RESUME:  accept_ok = susp_reg;
			FBMC_QUERY:   accept_ok = (mode_reg == M_READ) || (mode_reg == M_AUTOSEL);
			FBMC_SECT_ERASE, FBMC_CHIP_ERASE: accept_ok = !susp_reg && !erasing_reg;
			FBMC_BUF_PROGRAM: accept_ok = ({1'b0, req.count_m1} + 9'd5) <= 9'(MAX_BUF_CYCLES);
			default:      accept_ok = 1'b1;
		endcase
	end

	// ******************************
	// sequence table: cycle per step
	// ******************************
	always_comb begin
		cyc = '{addr: {{(ADDR_W-12){1'b0}}, ADR_AAA}, data: D_UNLK1, wr: 1'b1};
		if (step_reg == 9'd1) begin
			cyc.addr = {{(ADDR_W-12){1'b0}}, ADR_555};
			cyc.data = D_UNLK2;
		end
		unique case (cur_reg.op)
			FBMC_READ, FBMC_SSR_ENTER, FBMC_ECC_ENTER: begin
				if (cur_reg.op == FBMC_READ) begin
					cyc = '{addr: cur_reg.addr, data: 8'h00, wr: 1'b0};
				end else if (step_reg == 9'd2) begin
					cyc.data = (cur_reg.op == FBMC_SSR_ENTER) ? D_SSR_ENT : D_ECC_ENT;
				end
			end
			FBMC_RESET: cyc.data = (mode_reg == M_QUERY && cur_reg.data == D_RESET_A) ? D_RESET_A : D_RESET;
			FBMC_SUSPEND: cyc.data = D_SUSPEND;
			FBMC_RESUME:  cyc.data = D_RESUME;
			FBMC_QUERY:   cyc = '{addr: {{(ADDR_W-12){1'b0}}, ADR_AA}, data: D_QUERY, wr: 1'b1};
			FBMC_SR_CLEAR: cyc.data = D_SR_CLR;
			FBMC_SR_READ: if (step_reg == 9'd0) begin
				cyc.data = D_SR_RD;
			end else begin
				// status byte half picked by the lowest byte address bit
				cyc = '{addr: {{(ADDR_W-1){1'b0}}, cur_reg.addr[SR_BYTE_BIT]}, data: 8'h00, wr: 1'b0};
			end
			FBMC_AUTOSEL, FBMC_PROT_VERIFY: if (step_reg == 9'd2) begin
				cyc.data = D_AUTOSEL;
			end else if (step_reg == 9'd3) begin
				cyc = '{addr: (cur_reg.op == FBMC_PROT_VERIFY) ? (sect_base | ADR_PROT_VERIFY) : cur_reg.addr,
					data: 8'h00, wr: 1'b0};
			end
			FBMC_PROGRAM: if (step_reg == 9'd2) begin
				cyc.data = D_PROG;
			end else if (step_reg == 9'd3) begin
				cyc = '{addr: cur_reg.addr, data: cur_reg.data, wr: 1'b1};
			end
			FBMC_SECT_ERASE, FBMC_CHIP_ERASE: begin
				if (step_reg == 9'd2) cyc.data = D_ERASE;
				if (step_reg == 9'd4) cyc.addr = {{(ADDR_W-12){1'b0}}, ADR_555};
				if (step_reg == 9'd4) cyc.data = D_UNLK2;
				if (step_reg == 9'd5) begin
					cyc.addr = (cur_reg.op == FBMC_SECT_ERASE) ? sect_base : {{(ADDR_W-12){1'b0}}, ADR_AAA};
					cyc.data = (cur_reg.op == FBMC_SECT_ERASE) ? D_SECTOR : D_CHIP;
				end
			end
			FBMC_BUF_PROGRAM: if (step_reg == 9'd2) begin
				cyc = '{addr: sect_base, data: D_WBUF, wr: 1'b1};
			end else if (step_reg == 9'd3) begin
				cyc = '{addr: sect_base, data: cur_reg.count_m1, wr: 1'b1};
			end else if (step_reg == last_reg) begin
				cyc = '{addr: sect_base, data: D_CONFIRM, wr: 1'b1};
			end else if (step_reg >= 9'd4) begin
				cyc = '{addr: page_addr, data: buf_data, wr: 1'b1};
			end
			FBMC_ABORT: if (step_reg == 9'd2) begin
				cyc.data = D_RESET;
			end
		endcase
	end

	// ******************************
	// sequencer
	// ******************************
	always_comb begin
		st_next = st_reg;
		mode_next = mode_reg;
		cur_next = cur_reg;
		step_next = step_reg;
		last_next = last_reg;
		erasing_next = erasing_reg;
		susp_next = susp_reg;
		resp_next = resp_reg;
		rv_next = 1'b0;
		ref_next = 1'b0;
		tlf_next = tlf_reg;
		unique case (st_reg)
			H_IDLE: if (req_valid) begin
				if (accept_ok) begin
					cur_next = req;
					step_next = '0;
					unique case (req.op)
						FBMC_READ, FBMC_RESET, FBMC_SUSPEND, FBMC_RESUME, FBMC_QUERY, FBMC_SR_CLEAR:
							last_next = 9'd0;
						FBMC_SR_READ: last_next = 9'd1;
						FBMC_SSR_ENTER, FBMC_ECC_ENTER, FBMC_ABORT: last_next = 9'd2;
						FBMC_PROGRAM, FBMC_AUTOSEL, FBMC_PROT_VERIFY: last_next = 9'd3;
						FBMC_SECT_ERASE, FBMC_CHIP_ERASE: last_next = 9'd5;
						FBMC_BUF_PROGRAM: last_next = {1'b0, req.count_m1} + 9'd5;
						// continuity check not offered, so no width-dependent address is ever picked
					endcase
					st_next = H_STEP;
				end else begin
					// refused requests never reach the pins, so no partial sequence is left behind
					ref_next = 1'b1;
				end
			end
			H_STEP: if (cyc_ready) st_next = H_WAIT;
			H_WAIT: if (cyc_done) begin
				if (!cyc.wr) begin
					resp_next = cyc_rdata;
					tlf_next = cyc_rdata[TIME_LIMIT_BIT];
				end
				if (step_reg == last_reg) begin
					st_next = H_DONE;
				end else begin
					step_next = step_reg + 9'd1;
					st_next = H_STEP;
				end
			end
			H_DONE: begin
				rv_next = 1'b1;
				st_next = H_IDLE;
				unique case (cur_reg.op)
					FBMC_RESET, FBMC_ABORT: begin
						mode_next = M_READ;
						tlf_next = 1'b0;
					end
					FBMC_AUTOSEL, FBMC_PROT_VERIFY: mode_next = M_AUTOSEL;
					FBMC_QUERY: mode_next = M_QUERY;
					FBMC_SSR_ENTER: mode_next = M_SSR;
					FBMC_ECC_ENTER: mode_next = M_ECC;
					FBMC_SECT_ERASE: erasing_next = 1'b1;
					FBMC_CHIP_ERASE: erasing_next = 1'b0;
					FBMC_SUSPEND: susp_next = 1'b1;
					FBMC_RESUME: susp_next = 1'b0;
					default: ;
				endcase
				// a read of a done status (bit set) ends the erase tracking unless the erase is suspended
				if (cur_reg.op == FBMC_SR_READ && resp_reg[7]) erasing_next = susp_reg;
			end
			default: st_next = H_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_reg <= H_IDLE;
			mode_reg <= M_READ;
			cur_reg <= '0;
			step_reg <= '0;
			last_reg <= '0;
			erasing_reg <= 1'b0;
			susp_reg <= 1'b0;
			resp_reg <= '0;
			rv_reg <= 1'b0;
			ref_reg <= 1'b0;
			tlf_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			mode_reg <= mode_next;
			cur_reg <= cur_next;
			step_reg <= step_next;
			last_reg <= last_next;
			erasing_reg <= erasing_next;
			susp_reg <= susp_next;
			resp_reg <= resp_next;
			rv_reg <= rv_next;
			ref_reg <= ref_next;
			tlf_reg <= tlf_next;
		end
	end

	assign cyc_valid = (st_reg == H_STEP);
	assign req_ready = (st_reg == H_IDLE);
	assign buf_take = cyc_done && (cur_reg.op == FBMC_BUF_PROGRAM) && (step_reg >= 9'd4) && (step_reg != last_reg);
	assign resp_valid = rv_reg;
	assign resp_data = resp_reg;
	assign req_refused = ref_reg;
	assign suspended = susp_reg;
	assign time_limit_flag = tlf_reg;
endmodule // fbmc_host

//--- hw/fbmc_pkg.sv
// fbmc_pkg: constants, commands and carrier structs for the byte-mode flash host controller
// assumes: one 250 MHz clock, flash pins sampled synchronously
package fbmc_pkg;
	// ******************************
	// widths
	// ******************************
	localparam int ADDR_W = 23;
	localparam int DATA_W = 8;
	localparam int CLK_NS = 4;
	// ******************************
	// strobe timing, ns and cycles
	// ******************************
	localparam int T_SETUP_NS = 8;
	localparam int T_PULSE_NS = 36;
	localparam int T_RECOV_NS = 20;
	localparam int T_READ_NS  = 70;
	localparam int C_SETUP = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int C_PULSE = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int C_RECOV = (T_RECOV_NS + CLK_NS - 1) / CLK_NS;
	localparam int C_READ  = (T_READ_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W   = 6;
	// ******************************
	// command addresses and data
	// ******************************
	localparam logic [11:0] ADR_AAA   = 12'h0_AAA;
	localparam logic [11:0] ADR_555   = 12'h0_555;
	localparam logic [11:0] ADR_AA    = 12'h0_0AA;
	localparam logic [7:0]  D_UNLK1   = 8'h0_0AA;
	localparam logic [7:0]  D_UNLK2   = 8'h0_055;
	localparam logic [7:0]  D_RESET   = 8'h0_0F0;
	localparam logic [7:0]  D_RESET_A = 8'h0_0FF;
	localparam logic [7:0]  D_PROG    = 8'h0_0A0;
	localparam logic [7:0]  D_WBUF    = 8'h0_025;
	localparam logic [7:0]  D_CONFIRM = 8'h0_029;
	localparam logic [7:0]  D_AUTOSEL = 8'h0_090;
	localparam logic [7:0]  D_ERASE   = 8'h0_080;
	localparam logic [7:0]  D_SECTOR  = 8'h0_030;
	localparam logic [7:0]  D_CHIP    = 8'h0_010;
	localparam logic [7:0]  D_SUSPEND = 8'h0_0B0;
	localparam logic [7:0]  D_RESUME  = 8'h0_030;
	localparam logic [7:0]  D_QUERY   = 8'h0_098;
	localparam logic [7:0]  D_SSR_ENT = 8'h0_088;
	localparam logic [7:0]  D_ECC_ENT = 8'h0_075;
	localparam logic [7:0]  D_SR_RD   = 8'h0_070;
	localparam logic [7:0]  D_SR_CLR  = 8'h0_071;
	localparam logic [7:0]  D_EXIT2   = 8'h0_000;
	localparam logic [ADDR_W-1:0] ADR_PROT_VERIFY = 23'h00_0004;
	localparam int MAX_BUF_CYCLES = 261;
	localparam int MAX_BUF_BYTES  = 256;
	localparam int SECT_LSB_UNI  = 16;
	localparam int SECT_LSB_BOOT = 13;
	localparam int TIME_LIMIT_BIT = 5;
	localparam int SR_BYTE_BIT = 0;
	// ******************************
	// commands and carriers
	// ******************************
	typedef enum logic [3:0] {
		FBMC_READ, FBMC_RESET, FBMC_PROGRAM, FBMC_BUF_PROGRAM, FBMC_SECT_ERASE,
		FBMC_CHIP_ERASE, FBMC_SUSPEND, FBMC_RESUME, FBMC_QUERY, FBMC_SSR_ENTER,
		FBMC_ECC_ENTER, FBMC_AUTOSEL, FBMC_PROT_VERIFY, FBMC_SR_READ, FBMC_SR_CLEAR, FBMC_ABORT
	} fbmc_op_t;
	typedef struct packed {
		fbmc_op_t            op;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   data;
		logic [7:0]          count_m1;
		logic                boot_part;
	} fbmc_req_t;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic              wr;
	} fbmc_cyc_t;
	typedef struct packed {
		logic              ce_n;
		logic              we_n;
		logic              oe_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq_out;
		logic              dq_oe;
	} fbmc_pins_t;
endpackage

//--- testbench/fbmc_flash_model.sv
// fbmc_flash_model: behavioural byte-mode flash answering the host pins
// assumes: pins registered by the host; fault forces the time-limit status bit
`timescale 1ns/1ps
module fbmc_flash_model (
	// host pins
	input wire fbmc_pkg::fbmc_pins_t pins,
	input wire logic                 fault,
	// answers
	output logic                     bad,
	output logic [7:0]               dq_in
);
	import fbmc_pkg::*;
	logic [7:0]  mem [256];
	logic [15:0] sb [$];
	logic [22:0] a;
	logic [14:0] pg;
	logic [7:0]  last, rv;
	logic        erasing, susp, wact;
	int          st, md, left;
	initial begin
		st = 0; md = 0; left = 0; erasing = 0; susp = 0; wact = 0; bad = 0; last = 8'h00;
		foreach (mem[i]) mem[i] = 8'hff;
	end
	// ******************************
	// command decoding, one write cycle at a time
	// ******************************
	task automatic decode(input logic [22:0] ad, input logic [7:0] d);
		logic [11:0] c;
		c = ad[11:0];
		if (d == D_RESET || (d == D_RESET_A && md == 2)) begin
			md = 0;
			st = 0;
		end else case (st)
			0: if (c == ADR_AAA && d == D_UNLK1) st = 1;
				else if (c == ADR_AA && d == D_QUERY && md < 2) md = 2;
				else if (c == ADR_AAA && d == D_SR_RD) md = 3;
				else if (d == D_SUSPEND && erasing) susp = 1;
				else if (d == D_RESUME && susp) susp = 0;
			1: st = (c == ADR_555 && d == D_UNLK2) ? 2 : 0;
			2: case (d)
				D_PROG: st = 3;
				D_WBUF: st = 4;
				D_AUTOSEL: begin md = 1; st = 0; end
				D_ERASE: st = 6;
				default: st = 0;
			endcase
			3: begin mem[ad[7:0]] = d; st = 0; end
			4: begin left = d + 1; st = 5; sb.delete(); end
			5: if (left > 0) begin
					if (sb.size() == 0) pg = ad[22:8];
					if (ad[22:8] != pg) bad = 1'b1;
					sb.push_back({ad[7:0], d});
					left--;
				end else begin
					if (d != D_CONFIRM || sb.size() + 5 > MAX_BUF_CYCLES) bad = 1'b1;
					else foreach (sb[i]) mem[sb[i][15:8]] = sb[i][7:0];
					st = 0;
				end
			6: st = (c == ADR_AAA && d == D_UNLK1) ? 7 : 0;
			7: st = (c == ADR_555 && d == D_UNLK2) ? 8 : 0;
			default: begin erasing = (d == D_SECTOR); st = 0; end
		endcase
	endtask
	always @(negedge pins.we_n or negedge pins.ce_n)
		if (!pins.we_n && !pins.ce_n) begin
			a = pins.addr;
			wact = 1'b1;
		end
	always @(posedge pins.we_n or posedge pins.ce_n)
		if (wact) begin
			wact = 1'b0;
			decode(a, pins.dq_out);
		end
	// ******************************
	// read path
	// ******************************
	always_comb
		case (md)
			1: rv = (pins.addr[7:0] == 8'h04) ? {7'b0, pins.addr[SECT_LSB_UNI]} : 8'h00;
			2: rv = 8'h51;
			3: rv = pins.addr[SR_BYTE_BIT] ? 8'h00 : {~erasing, 1'b0, fault, 5'b0};
			default: rv = mem[pins.addr[7:0]];
		endcase
	// the erase finishes once a busy status has been read, so tracking can be seen to end
	always @(posedge pins.oe_n) begin
		last = rv;
		if (md == 3) begin
			erasing = 1'b0;
			md = 0;
		end
	end
	// released bus shows the inverse of the last byte, never a stale match
	assign dq_in = (!pins.oe_n && !pins.ce_n) ? rv : ~last;
endmodule // fbmc_flash_model

//--- testbench/fbmc_host_monitor.sv
// fbmc_host_monitor: port assertions for the flash host controller
// assumes: bound into fbmc_host, one clock, synchronous reset active low
`timescale 1ns/1ps
module fbmc_host_monitor (
	// clock and reset
	input wire logic                 clk,
	input wire logic                 rst_n,
	// request side
	input wire fbmc_pkg::fbmc_req_t  req,
	input wire logic                 req_valid,
	input wire logic                 req_ready,
	input wire logic                 req_refused,
	input wire logic                 suspended,
	// flash pins
	input wire fbmc_pkg::fbmc_pins_t pins
);
	import fbmc_pkg::*;
	logic take;
	assign take = req_valid && req_ready;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ******************************
	// bus cycle shape
	// ******************************
	chk_we_in_ce: assert property (!pins.we_n |-> !pins.ce_n)
		else $error("write strobe outside chip enable");
	chk_addr_hold: assert property (!pins.ce_n && $past(!pins.ce_n) |-> $stable(pins.addr))
		else $error("address moved inside a bus cycle");
	chk_data_hold: assert property (!pins.we_n |-> pins.dq_oe && $stable(pins.dq_out))
		else $error("write data not held under strobe");
	chk_we_pulse: assert property ($fell(pins.we_n) |-> (!pins.we_n) [*8])
		else $error("write strobe too short");
	chk_we_rise_first: assert property ($rose(pins.we_n) |-> !pins.ce_n)
		else $error("chip enable rose before write strobe");
	chk_strobe_excl: assert property (!(!pins.we_n && !pins.oe_n))
		else $error("read and write strobes both low");
	// ******************************
	// suspend and resume validity
	// ******************************
	chk_suspend_refuse: assert property (take && req.op == FBMC_SUSPEND && suspended |=> req_refused)
		else $error("second suspend not refused");
	chk_resume_refuse: assert property (take && req.op == FBMC_RESUME && !suspended |=> req_refused)
		else $error("resume accepted while not suspended");
	chk_resume_clears: assert property (take && req.op == FBMC_RESUME && suspended |-> ##[1:200] !suspended)
		else $error("resume did not clear suspended");
	chk_refused_quiet: assert property (req_refused |-> pins.ce_n && pins.we_n)
		else $error("refused request drove a bus cycle");
endmodule // fbmc_host_monitor

bind fbmc_host fbmc_host_monitor fbmc_host_monitor_inst (.clk(clk), .rst_n(rst_n), .req(req), .req_valid(req_valid),
	.req_ready(req_ready), .req_refused(req_refused), .suspended(suspended), .pins(pins));

//--- testbench/test_flash_byte_mode_command_decoder.sv
// test_flash_byte_mode_command_decoder: self-checking bench for fbmc_host with a flash model
// assumes: fbmc_pkg, fbmc_host, fbmc_flash_model and the bound monitor are compiled first
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin mismatches++; \
	$display("wrong value %s expected %h seen %h", nm, ex, got); end end
module test_flash_byte_mode_command_decoder;
	import fbmc_pkg::*;
	logic        clk, rst_n, req_valid, req_ready, buf_take, resp_valid, req_refused;
	logic        suspended, time_limit_flag, fault, bad;
	fbmc_req_t   req;
	fbmc_pins_t  pins;
	logic [7:0]  buf_data, resp_data, dq_in, lr, pv;
	logic [8:0]  expq [$];
	logic [8:0]  ev;
	logic [7:0]  bb [4];
	logic [31:0] seed;
	int          mismatches, compares, bi;
	fbmc_host fbmc_host_inst (.clk(clk), .rst_n(rst_n), .req(req), .req_valid(req_valid), .req_ready(req_ready),
		.buf_data(buf_data), .buf_take(buf_take), .resp_valid(resp_valid), .resp_data(resp_data),
		.req_refused(req_refused), .suspended(suspended), .time_limit_flag(time_limit_flag), .pins(pins), .dq_in(dq_in));
	fbmc_flash_model fbmc_flash_model_inst (.pins(pins), .fault(fault), .bad(bad), .dq_in(dq_in));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// ******************************
	// request driver: note the expectation, hold until taken, wait for the answer
	// ******************************
	task automatic op(input fbmc_op_t o, input logic [22:0] ad, input logic [7:0] d, input logic rf, input logic [7:0] e);
		int n;
		expq.push_back({rf, e});
		req = '{o, ad, d, 8'h03, 1'b0};
		req_valid = 1'b1;
		while (!req_ready) @(negedge clk);
		@(negedge clk);
		req_valid = 1'b0;
		n = 0;
		while (!(resp_valid || req_refused) && n < 3000) begin
			@(negedge clk);
			n++;
		end
		if (n == 3000) begin
			mismatches++;
			conclude();
		end else begin
			@(negedge clk);
		end
	endtask
	task automatic rd(input fbmc_op_t o, input logic [22:0] ad, input logic [7:0] e);
		op(o, ad, 8'h00, 1'b0, e);
		lr = e;
	endtask
	task automatic wr(input fbmc_op_t o, input logic [22:0] ad, input logic [7:0] d);
		op(o, ad, d, 1'b0, lr);
	endtask
	task automatic no(input fbmc_op_t o);
		op(o, 23'h00_0000, 8'h00, 1'b1, lr);
	endtask
	// ******************************
	// answer watcher and buffer feeder
	// ******************************
	always @(negedge clk)
		if (rst_n && (resp_valid || req_refused)) begin
			if (expq.size() == 0) mismatches++;
			else begin
				ev = expq.pop_front();
				`CHK("response", ev, {req_refused, resp_data})
			end
		end
	always @(negedge clk)
		if (buf_take) bi <= bi + 1;
	assign buf_data = bb[bi[1:0]];
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#100000;
		mismatches++;
		conclude();
	end
	initial begin
		rst_n = 0; req_valid = 0; req = '0; fault = 0; bi = 0; lr = 8'h00; mismatches = 0; compares = 0;
		seed = 32'h5de7;
		foreach (bb[i]) begin
			seed = lfsr(seed);
			bb[i] = seed[7:0];
		end
		seed = lfsr(seed);
		pv = seed[7:0];
		repeat (8) @(negedge clk);
		rst_n = 1;
		wr(FBMC_PROGRAM, 23'h7f_f040, pv);
		rd(FBMC_READ, 23'h00_0040, pv);
		wr(FBMC_BUF_PROGRAM, 23'h01_0010, 8'h00);
		for (int i = 0; i < 4; i++) rd(FBMC_READ, 23'h01_0010 + 23'(i), bb[i]);
		rd(FBMC_PROT_VERIFY, 23'h01_0000, 8'h01);
		wr(FBMC_RESET, 23'h00_0000, D_RESET);
		rd(FBMC_PROT_VERIFY, 23'h02_0000, 8'h00);
		wr(FBMC_RESET, 23'h00_0000, D_RESET);
		no(FBMC_SUSPEND);
		no(FBMC_RESUME);
		wr(FBMC_SECT_ERASE, 23'h03_0000, 8'h00);
		wr(FBMC_SUSPEND, 23'h00_0000, 8'h00);
		`CHK("suspended", 1'b1, suspended)
		no(FBMC_SUSPEND);
		no(FBMC_SECT_ERASE);
		wr(FBMC_RESUME, 23'h00_0000, 8'h00);
		`CHK("suspended", 1'b0, suspended)
		rd(FBMC_SR_READ, 23'h00_0000, 8'h00);
		rd(FBMC_SR_READ, 23'h00_0001, 8'h00);
		rd(FBMC_SR_READ, 23'h00_0000, 8'h80);
		no(FBMC_SUSPEND);
		wr(FBMC_QUERY, 23'h00_0000, D_QUERY);
		rd(FBMC_READ, 23'h00_0000, 8'h51);
		no(FBMC_QUERY);
		wr(FBMC_RESET, 23'h00_0000, D_RESET_A);
		rd(FBMC_READ, 23'h00_0040, pv);
		wr(FBMC_ABORT, 23'h00_0000, 8'h00);
		wr(FBMC_PROGRAM, 23'h00_0050, 8'h3c);
		rd(FBMC_READ, 23'h00_0050, 8'h3c);
		fault = 1'b1;
		rd(FBMC_SR_READ, 23'h00_0000, 8'ha0);
		`CHK("time_limit_flag", 1'b1, time_limit_flag)
		wr(FBMC_RESET, 23'h00_0000, D_RESET);
		`CHK("time_limit_flag", 1'b0, time_limit_flag)
		fault = 1'b0;
		wr(FBMC_SSR_ENTER, 23'h00_0000, 8'h00);
		no(FBMC_QUERY);
		wr(FBMC_RESET, 23'h00_0000, D_RESET);
		rd(FBMC_AUTOSEL, 23'h00_0000, 8'h00);
		wr(FBMC_QUERY, 23'h00_0000, D_QUERY);
		rd(FBMC_READ, 23'h00_0000, 8'h51);
		wr(FBMC_RESET, 23'h00_0000, D_RESET);
		wr(FBMC_SR_CLEAR, 23'h00_0000, 8'h00);
		wr(FBMC_CHIP_ERASE, 23'h00_0000, 8'h00);
		no(FBMC_SUSPEND);
		wr(FBMC_ECC_ENTER, 23'h00_0000, 8'h00);
		wr(FBMC_RESET, 23'h00_0000, D_RESET);
		`CHK("protocol", 1'b0, bad)
		conclude();
	end
endmodule // test_flash_byte_mode_command_decoder
